// *** shared/cpo_regs.vh ***
// register map, field positions and reset values of the operator signal block
`ifndef CPO_REGS_VH
`define CPO_REGS_VH
// register byte offsets
`define CPO_OFF_CTRL 6'h00
`define CPO_OFF_BLOCK 6'h04
`define CPO_OFF_STATUS 6'h08
`define CPO_OFF_MREG_LO 6'h0C
`define CPO_OFF_MREG_HI 6'h10
`define CPO_OFF_RAPID_RATE 6'h14
`define CPO_OFF_RAPID_LOW 6'h18
`define CPO_OFF_SPEED 6'h1C
`define CPO_OFF_AXIS_ORDER 6'h20
`define CPO_OFF_PINS 6'h24
// control fields
`define CPO_CTRL_AUTO 0
`define CPO_CTRL_START 1
`define CPO_CTRL_MOTION_DONE 2
`define CPO_CTRL_CNC_RESET 3
// block descriptor fields
`define CPO_BLK_THREAD 0
`define CPO_BLK_NEXT_THREAD 1
`define CPO_BLK_SLASH 2
`define CPO_BLK_CANNED 5:4
`define CPO_BLK_MCOUNT 7:6
`define CPO_BLK_M0 13:8
`define CPO_BLK_M1 21:16
`define CPO_BLK_M2 29:24
// status fields
`define CPO_ST_ALARM 8
// operation select byte, test status byte, restart status byte bits
`define CPO_SEL_SKIP 0
`define CPO_SEL_STEP 1
`define CPO_SEL_RESTART 6
`define CPO_TST_SKIP_ECHO 0
`define CPO_RST_IN_PROG 4
// override figures in percent, and the highest stepped feed code
`define CPO_PCT_FULL 8'h64
`define CPO_PCT_MAX 8'hC8
`define CPO_PCT_STEP 8'h0A
`define CPO_FEED_CODE_MAX 5'h14
// rapid override codes {a,b}
`define CPO_RV_FULL 2'h3
`define CPO_RV_HALF 2'h1
`define CPO_RV_QUARTER 2'h2
// reset values
`define CPO_RST_RAPID_RATE 16'h1000
`define CPO_RST_RAPID_LOW 16'h0100
`define CPO_RST_AXIS_ORDER 8'hE4
`define CPO_RST_MREG 32'hFFFFFFFF
`endif

// *** rtl/cpo_operation_signals.v ***
// cnc side of the plc operator signals: step, skip, restart, overrides, m codes
// Overview of operation
// - single step in thread cutting stops only before first non-thread block
// - canned cycle with single step stops at each step, feed hold raised at all but the last
// - block done under single step: both indicators low, stay stopped
// - slash block skipped in auto while optional skip input is high
// - optional skip echo output mirrors the optional skip input
// - restart select rising in auto: search restart block, show restart screen
// - restart select low in auto: axes move in order at dry run
// - restart in progress set on select in auto, cleared after last axis
// - rapid override code: 11 full, 01 half, 10 quarter, 00 low rate
// - rapid speed is parameter rate times selected override, low rate parameter for 00
// - feed override from 5-bit code in 10 percent steps to 200
// - override cancel high holds feed override at 100 percent
// - override cancel leaves rapid override untouched
// - unregistered m code raises alarm; each code owns one bit
// - m codes run with motion; several per block issue in sequence
// - m code bit and strobe rise together; plc drops response
// - next block waits until common finish seen high
// - cnc reset clears strobe outputs well within 16 ms
`timescale 1ns/10ps
`default_nettype none
`include "cpo_regs.vh"
module cpo_operation_signals #(
	parameter N_AXES = 4,
	parameter RATE_W = 16
) (
	input wire CORE_CLK,
	input wire RST_N,
	input wire PSEL,
	input wire PENABLE,
	input wire PWRITE,
	input wire [5:0] PADDR,
	input wire [31:0] PWDATA,
	output reg [31:0] PRDATA,
	output reg PREADY,
	output reg PSLVERR,
	input wire SINGLE_STEP_INPUT,
	input wire OPTIONAL_SKIP_INPUT,
	input wire RESTART_SELECT_INPUT,
	input wire RAPID_OVERRIDE_CODE_A,
	input wire RAPID_OVERRIDE_CODE_B,
	input wire [4:0] FEED_OVERRIDE_CODE,
	input wire OVERRIDE_CANCEL_INPUT,
	input wire COMMON_FINISH_INPUT,
	input wire M_FINISH_INPUT,
	input wire M_RESPONSE_INPUT,
	output reg CYCLE_START_INDICATOR,
	output reg FEED_HOLD_INDICATOR,
	output reg OPTIONAL_SKIP_ECHO,
	output reg RESTART_IN_PROGRESS,
	output reg RESTART_SCREEN,
	output reg DRY_RUN_MOVE,
	output reg [1:0] RESTART_AXIS,
	output reg M_STROBE,
	output reg [63:0] M_CODE_BITS,
	output reg M_ALARM,
	output reg [RATE_W-1:0] RAPID_SPEED,
	output reg [7:0] FEED_OVERRIDE_PCT
);
	localparam ST_IDLE = 3'h0;
	localparam ST_EXEC = 3'h1;
	localparam ST_HOLD = 3'h2;
	localparam ST_SEARCH = 3'h3;
	localparam ST_MOVE = 3'h4;

	reg rst_meta;
	reg rst_sync;
	reg [2:0] state;
	reg auto_mode;
	reg running;
	reg blk_valid;
	reg [31:0] blk;
	reg [31:0] cur;
	reg [1:0] can_left;
	reg [1:0] m_left;
	reg [1:0] m_ptr;
	reg mot_fin;
	reg [63:0] mreg;
	reg [RATE_W-1:0] rapid_rate;
	reg [RATE_W-1:0] rapid_low;
	reg [7:0] axis_order;
	reg [1:0] axis_cnt;
	reg restart_prev;
	reg [7:0] feed_pct_raw;
	reg [5:0] m_code;
	reg [31:0] rd_val;
	reg rd_hit;

	wire acc = PSEL & PENABLE & PREADY;
	wire wr = acc & PWRITE;
	wire wr_ctrl = wr & (PADDR == `CPO_OFF_CTRL);
	wire start_req = wr_ctrl & PWDATA[`CPO_CTRL_START];
	wire mot_done = wr_ctrl & PWDATA[`CPO_CTRL_MOTION_DONE];
	wire cnc_reset = wr_ctrl & PWDATA[`CPO_CTRL_CNC_RESET];
	wire [1:0] rv_code = {RAPID_OVERRIDE_CODE_A, RAPID_OVERRIDE_CODE_B};
	wire restart_rise = RESTART_SELECT_INPUT & ~restart_prev;
	wire step_stop = SINGLE_STEP_INPUT &
		~(cur[`CPO_BLK_THREAD] & cur[`CPO_BLK_NEXT_THREAD]);
	wire blk_end = mot_fin & (m_left == 2'h0) & ~M_STROBE;
	wire m_alarm_set;

	// reset release through two flops, assert stays asynchronous
	always @(posedge CORE_CLK or negedge RST_N) begin
		if (!RST_N) begin
			rst_meta <= 1'b0;
			rst_sync <= 1'b0;
		end else begin
			rst_meta <= 1'b1;
			rst_sync <= rst_meta;
		end
	end

	// current m code of the block, picked by the sequence pointer
	always @* begin
		case (m_ptr)
		2'h0: m_code = cur[`CPO_BLK_M0];
		2'h1: m_code = cur[`CPO_BLK_M1];
		default: m_code = cur[`CPO_BLK_M2];
		endcase
	end

	// issue only once the previous finish has dropped, else it is reused
	wire m_issue = (state == ST_EXEC) & ~M_STROBE & (m_left != 2'h0) &
		~COMMON_FINISH_INPUT;
	assign m_alarm_set = m_issue & ~mreg[m_code];

	// feed override decode, cancel forces full rate
	always @* begin
		if (FEED_OVERRIDE_CODE > `CPO_FEED_CODE_MAX)
			feed_pct_raw = `CPO_PCT_MAX;
		else
			feed_pct_raw = {3'h0, FEED_OVERRIDE_CODE} * `CPO_PCT_STEP;
	end

	// override outputs; cancel only touches the cutting feed path
	always @(posedge CORE_CLK or negedge rst_sync) begin
		if (!rst_sync) begin
			FEED_OVERRIDE_PCT <= `CPO_PCT_FULL;
			RAPID_SPEED <= {RATE_W{1'b0}};
			OPTIONAL_SKIP_ECHO <= 1'b0;
		end else begin
			if (OVERRIDE_CANCEL_INPUT)
				FEED_OVERRIDE_PCT <= `CPO_PCT_FULL;
			else
				FEED_OVERRIDE_PCT <= feed_pct_raw;
			if (rv_code == `CPO_RV_FULL)
				RAPID_SPEED <= rapid_rate;
			else if (rv_code == `CPO_RV_HALF)
				RAPID_SPEED <= rapid_rate >> 1;
			else if (rv_code == `CPO_RV_QUARTER)
				RAPID_SPEED <= rapid_rate >> 2;
			else
				RAPID_SPEED <= rapid_low;
			OPTIONAL_SKIP_ECHO <= OPTIONAL_SKIP_INPUT;
		end
	end

	// block sequencer, m handshake and restart sequence
	always @(posedge CORE_CLK or negedge rst_sync) begin
		if (!rst_sync) begin
			state <= ST_IDLE;
			running <= 1'b0;
			cur <= 32'h0;
			can_left <= 2'h0;
			m_left <= 2'h0;
			m_ptr <= 2'h0;
			mot_fin <= 1'b0;
			axis_cnt <= 2'h0;
			restart_prev <= 1'b0;
			CYCLE_START_INDICATOR <= 1'b0;
			FEED_HOLD_INDICATOR <= 1'b0;
			RESTART_IN_PROGRESS <= 1'b0;
			RESTART_SCREEN <= 1'b0;
			DRY_RUN_MOVE <= 1'b0;
			RESTART_AXIS <= 2'h0;
			M_STROBE <= 1'b0;
			M_CODE_BITS <= 64'h0;
		end else begin
			restart_prev <= RESTART_SELECT_INPUT;
			if (cnc_reset) begin
				// strobe drops the next edge, far inside the reset limit
				state <= ST_IDLE;
				running <= 1'b0;
				m_left <= 2'h0;
				M_STROBE <= 1'b0;
				M_CODE_BITS <= 64'h0;
				CYCLE_START_INDICATOR <= 1'b0;
				FEED_HOLD_INDICATOR <= 1'b0;
				RESTART_IN_PROGRESS <= 1'b0;
				RESTART_SCREEN <= 1'b0;
				DRY_RUN_MOVE <= 1'b0;
			end else begin
				case (state)
				ST_IDLE: begin
					FEED_HOLD_INDICATOR <= 1'b0;
					CYCLE_START_INDICATOR <= running | start_req;
					if (start_req)
						running <= 1'b1;
					if (restart_rise & auto_mode) begin
						state <= ST_SEARCH;
						RESTART_IN_PROGRESS <= 1'b1;
						RESTART_SCREEN <= 1'b1;
						running <= 1'b0;
						CYCLE_START_INDICATOR <= 1'b0;
					end else if ((running | start_req) & auto_mode &
						blk_valid & ~(blk[`CPO_BLK_SLASH] &
						OPTIONAL_SKIP_INPUT)) begin
						// skipped slash blocks never reach this load
						state <= ST_EXEC;
						cur <= blk;
						can_left <= blk[`CPO_BLK_CANNED];
						m_left <= blk[`CPO_BLK_MCOUNT];
						m_ptr <= 2'h0;
						mot_fin <= 1'b0;
					end
				end
				ST_EXEC: begin
					// motion and m codes progress side by side
					if (mot_done) begin
						if (can_left != 2'h0) begin
							can_left <= can_left - 2'h1;
							if (SINGLE_STEP_INPUT) begin
								state <= ST_HOLD;
								CYCLE_START_INDICATOR <= 1'b0;
								FEED_HOLD_INDICATOR <= 1'b1;
							end
						end else begin
							mot_fin <= 1'b1;
						end
					end
					if (m_issue) begin
						if (mreg[m_code]) begin
							M_STROBE <= 1'b1;
							M_CODE_BITS <= 64'h1 << m_code;
						end else begin
							m_left <= m_left - 2'h1;
							m_ptr <= m_ptr + 2'h1;
						end
					end else if (M_STROBE & COMMON_FINISH_INPUT) begin
						M_STROBE <= 1'b0;
						M_CODE_BITS <= 64'h0;
						m_left <= m_left - 2'h1;
						m_ptr <= m_ptr + 2'h1;
					end
					if (blk_end) begin
						state <= ST_IDLE;
						if (step_stop) begin
							running <= 1'b0;
							CYCLE_START_INDICATOR <= 1'b0;
							FEED_HOLD_INDICATOR <= 1'b0;
						end
					end
				end
				ST_HOLD: begin
					// intermediate canned stop; m handshake keeps running
					if (M_STROBE & COMMON_FINISH_INPUT) begin
						M_STROBE <= 1'b0;
						M_CODE_BITS <= 64'h0;
						m_left <= m_left - 2'h1;
						m_ptr <= m_ptr + 2'h1;
					end
					if (start_req) begin
						state <= ST_EXEC;
						CYCLE_START_INDICATOR <= 1'b1;
						FEED_HOLD_INDICATOR <= 1'b0;
					end
				end
				ST_SEARCH: begin
					// software searches the sequence number meanwhile
					if (~RESTART_SELECT_INPUT & auto_mode) begin
						state <= ST_MOVE;
						RESTART_SCREEN <= 1'b0;
						DRY_RUN_MOVE <= 1'b1;
						axis_cnt <= 2'h0;
						RESTART_AXIS <= axis_order[1:0];
					end
				end
				ST_MOVE: begin
					// one axis at a time, in the programmed order
					if (mot_done) begin
						if (axis_cnt == N_AXES - 1) begin
							state <= ST_IDLE;
							RESTART_IN_PROGRESS <= 1'b0;
							DRY_RUN_MOVE <= 1'b0;
							running <= 1'b1;
							CYCLE_START_INDICATOR <= 1'b1;
						end else begin
							axis_cnt <= axis_cnt + 2'h1;
							RESTART_AXIS <= axis_order[
								{axis_cnt + 2'h1, 1'b0} +: 2];
						end
					end
				end
				default: state <= ST_IDLE;
				endcase
			end
		end
	end

	// software registers; block valid clears when loaded or skipped
	always @(posedge CORE_CLK or negedge rst_sync) begin
		if (!rst_sync) begin
			auto_mode <= 1'b0;
			blk_valid <= 1'b0;
			blk <= 32'h0;
			mreg <= {`CPO_RST_MREG, `CPO_RST_MREG};
			rapid_rate <= `CPO_RST_RAPID_RATE;
			rapid_low <= `CPO_RST_RAPID_LOW;
			axis_order <= `CPO_RST_AXIS_ORDER;
			M_ALARM <= 1'b0;
		end else begin
			if (state == ST_IDLE & blk_valid & blk[`CPO_BLK_SLASH] &
				OPTIONAL_SKIP_INPUT & auto_mode)
				blk_valid <= 1'b0;
			else if (state == ST_IDLE & (running | start_req) &
				auto_mode & blk_valid & ~restart_rise & ~cnc_reset)
				blk_valid <= 1'b0;
			if (wr_ctrl)
				auto_mode <= PWDATA[`CPO_CTRL_AUTO];
			if (wr & PADDR == `CPO_OFF_BLOCK) begin
				blk <= PWDATA;
				blk_valid <= 1'b1;
			end
			if (wr & PADDR == `CPO_OFF_MREG_LO)
				mreg[31:0] <= PWDATA;
			if (wr & PADDR == `CPO_OFF_MREG_HI)
				mreg[63:32] <= PWDATA;
			if (wr & PADDR == `CPO_OFF_RAPID_RATE)
				rapid_rate <= PWDATA[RATE_W-1:0];
			if (wr & PADDR == `CPO_OFF_RAPID_LOW)
				rapid_low <= PWDATA[RATE_W-1:0];
			if (wr & PADDR == `CPO_OFF_AXIS_ORDER)
				axis_order <= PWDATA[7:0];
			// sticky alarm: a new set beats a same-cycle clear
			if (m_alarm_set)
				M_ALARM <= 1'b1;
			else if (wr & PADDR == `CPO_OFF_STATUS &
				PWDATA[`CPO_ST_ALARM])
				M_ALARM <= 1'b0;
		end
	end

	// read mux
	always @* begin
		rd_val = 32'h0;
		rd_hit = 1'b1;
		if (PADDR == `CPO_OFF_CTRL)
			rd_val = {31'h0, auto_mode};
		else if (PADDR == `CPO_OFF_BLOCK)
			rd_val = blk;
		else if (PADDR == `CPO_OFF_STATUS)
			rd_val = {12'h0, M_RESPONSE_INPUT, M_FINISH_INPUT,
				axis_cnt, m_ptr, m_left, 3'h0, M_ALARM, running,
				blk_valid, mot_fin, M_STROBE, 1'b0, state};
		else if (PADDR == `CPO_OFF_MREG_LO)
			rd_val = mreg[31:0];
		else if (PADDR == `CPO_OFF_MREG_HI)
			rd_val = mreg[63:32];
		else if (PADDR == `CPO_OFF_RAPID_RATE)
			rd_val = {{(32-RATE_W){1'b0}}, rapid_rate};
		else if (PADDR == `CPO_OFF_RAPID_LOW)
			rd_val = {{(32-RATE_W){1'b0}}, rapid_low};
		else if (PADDR == `CPO_OFF_SPEED)
			rd_val = {{(24-RATE_W){1'b0}}, FEED_OVERRIDE_PCT, RAPID_SPEED};
		else if (PADDR == `CPO_OFF_AXIS_ORDER)
			rd_val = {24'h0, axis_order};
		else if (PADDR == `CPO_OFF_PINS)
			rd_val = {11'h0, RESTART_IN_PROGRESS, 4'h0, 7'h0,
				OPTIONAL_SKIP_ECHO, 1'b0, RESTART_SELECT_INPUT,
				4'h0, SINGLE_STEP_INPUT, OPTIONAL_SKIP_INPUT};
		else
			rd_hit = 1'b0;
	end

	// apb slave: one wait state, answer registered
	always @(posedge CORE_CLK or negedge rst_sync) begin
		if (!rst_sync) begin
			PREADY <= 1'b0;
			PRDATA <= 32'h0;
			PSLVERR <= 1'b0;
		end else begin
			PREADY <= PSEL & PENABLE & ~PREADY;
			if (PSEL & PENABLE & ~PREADY) begin
				PRDATA <= PWRITE ? 32'h0 : rd_val;
				PSLVERR <= ~rd_hit;
			end else begin
				PSLVERR <= 1'b0;
			end
		end
	end
endmodule // cpo_operation_signals
`default_nettype wire

// *** bench/cpo_plc_model.sv ***
// machine plc stand-in that answers the m code handshake
`timescale 1ns/10ps
`default_nettype none
module cpo_plc_model (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic strobe,
	input wire logic [3:0] dly,
	output logic common_finish_input,
	output logic m_finish_input,
	output logic response_input
);
	logic [3:0] cnt;
	// finish after a chosen delay; long delays stress the cnc wait
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			{common_finish_input, m_finish_input, response_input} <= 3'h1;
			cnt <= 4'h0;
		end else if (strobe) begin
			response_input <= 1'h0;
			cnt <= cnt + 4'h1;
			if (cnt == dly) {common_finish_input, m_finish_input} <= 2'h3;
		end else begin
			{common_finish_input, m_finish_input} <= 2'h0;
			response_input <= 1'h1;
			cnt <= 4'h0;
		end
	end
endmodule // cpo_plc_model
`default_nettype wire

// *** bench/cpo_monitor.sv ***
// port-level checker for the operator signal block
`timescale 1ns/10ps
`default_nettype none
module cpo_monitor (
	input wire logic CORE_CLK,
	input wire logic RST_N,
	input wire logic PSEL,
	input wire logic PENABLE,
	input wire logic PWRITE,
	input wire logic PREADY,
	input wire logic OPTIONAL_SKIP_INPUT,
	input wire logic OPTIONAL_SKIP_ECHO,
	input wire logic OVERRIDE_CANCEL_INPUT,
	input wire logic [4:0] FEED_OVERRIDE_CODE,
	input wire logic [7:0] FEED_OVERRIDE_PCT,
	input wire logic M_STROBE,
	input wire logic [63:0] M_CODE_BITS,
	input wire logic COMMON_FINISH_INPUT,
	input wire logic CYCLE_START_INDICATOR,
	input wire logic FEED_HOLD_INDICATOR,
	input wire logic RESTART_SELECT_INPUT,
	input wire logic RESTART_IN_PROGRESS
);
	logic [2:0] up;
	logic wr;
	// outputs lag the reset copy, so checking waits a few edges
	always @(posedge CORE_CLK or negedge RST_N) begin
		if (!RST_N) up <= 3'h0;
		else if (up != 3'h7) up <= up + 3'h1;
	end
	assign wr = PSEL && PENABLE && PREADY && PWRITE;
	default clocking cb @(posedge CORE_CLK); endclocking
	default disable iff (!RST_N || up != 3'h7);
	skip_echo_a: assert property (
		OPTIONAL_SKIP_ECHO == $past(OPTIONAL_SKIP_INPUT))
		else $error("skip echo differs from input");
	cancel_hold_a: assert property (
		$past(OVERRIDE_CANCEL_INPUT) |-> FEED_OVERRIDE_PCT == 8'h64)
		else $error("cancel did not force full feed");
	feed_step_a: assert property (
		!$past(OVERRIDE_CANCEL_INPUT) && $past(FEED_OVERRIDE_CODE) <= 5'h14
		|-> FEED_OVERRIDE_PCT == $past(FEED_OVERRIDE_CODE) * 8'h0A)
		else $error("feed percent wrong for code");
	feed_clip_a: assert property (
		!$past(OVERRIDE_CANCEL_INPUT) && $past(FEED_OVERRIDE_CODE) > 5'h14
		|-> FEED_OVERRIDE_PCT == 8'hC8)
		else $error("feed percent not clipped at top");
	code_onehot_a: assert property (
		M_STROBE |-> $onehot(M_CODE_BITS))
		else $error("m code bits not one-hot");
	bits_idle_a: assert property (
		!M_STROBE |-> M_CODE_BITS == 64'h0)
		else $error("m code bit without strobe");
	strobe_hold_a: assert property (
		$past(M_STROBE) && !$past(COMMON_FINISH_INPUT) && !$past(wr)
		|-> M_STROBE && $stable(M_CODE_BITS))
		else $error("strobe dropped before finish");
	strobe_drop_a: assert property (
		M_STROBE && COMMON_FINISH_INPUT |-> ##[1:2] !M_STROBE)
		else $error("strobe kept after finish");
	new_code_a: assert property (
		$rose(M_STROBE) |-> !$past(COMMON_FINISH_INPUT))
		else $error("m code issued while finish high");
	lamp_excl_a: assert property (
		!(CYCLE_START_INDICATOR && FEED_HOLD_INDICATOR))
		else $error("start and hold lamps both high");
	restart_set_a: assert property (
		$rose(RESTART_IN_PROGRESS) |-> $past(RESTART_SELECT_INPUT))
		else $error("restart flag without select");
	cover property ($rose(M_STROBE));
	cover property ($rose(FEED_HOLD_INDICATOR));
	cover property ($fell(RESTART_IN_PROGRESS));
endmodule // cpo_monitor
bind cpo_operation_signals cpo_monitor mon_u (.CORE_CLK, .RST_N, .PSEL,
	.PENABLE, .PWRITE, .PREADY, .OPTIONAL_SKIP_INPUT, .OPTIONAL_SKIP_ECHO,
	.OVERRIDE_CANCEL_INPUT, .FEED_OVERRIDE_CODE, .FEED_OVERRIDE_PCT,
	.M_STROBE, .M_CODE_BITS, .COMMON_FINISH_INPUT, .CYCLE_START_INDICATOR,
	.FEED_HOLD_INDICATOR, .RESTART_SELECT_INPUT, .RESTART_IN_PROGRESS);
`default_nettype wire

// *** bench/test_cpo_operation_signals.sv ***
// self-checking bench for the operator signal block
`timescale 1ns/10ps
`default_nettype none
`include "cpo_regs.vh"
module test_cpo_operation_signals;
	logic CORE_CLK, RST_N, PSEL, PENABLE, PWRITE, PREADY, PSLVERR, er;
	logic [5:0] PADDR;
	logic [31:0] PWDATA, PRDATA, rd, v;
	logic SINGLE_STEP_INPUT, OPTIONAL_SKIP_INPUT, RESTART_SELECT_INPUT;
	logic RAPID_OVERRIDE_CODE_A, RAPID_OVERRIDE_CODE_B, OVERRIDE_CANCEL_INPUT;
	logic [4:0] FEED_OVERRIDE_CODE;
	logic COMMON_FINISH_INPUT, M_FINISH_INPUT, M_RESPONSE_INPUT, M_ALARM;
	logic CYCLE_START_INDICATOR, FEED_HOLD_INDICATOR, OPTIONAL_SKIP_ECHO;
	logic RESTART_IN_PROGRESS, RESTART_SCREEN, DRY_RUN_MOVE, M_STROBE;
	logic [1:0] RESTART_AXIS;
	logic [63:0] M_CODE_BITS;
	logic [15:0] RAPID_SPEED, rs;
	logic [7:0] FEED_OVERRIDE_PCT;
	logic [3:0] dly;
	integer bad_count, compares, i, k, pct;
	cpo_operation_signals dut_u (.CORE_CLK, .RST_N, .PSEL, .PENABLE, .PWRITE,
		.PADDR, .PWDATA, .PRDATA, .PREADY, .PSLVERR, .SINGLE_STEP_INPUT,
		.OPTIONAL_SKIP_INPUT, .RESTART_SELECT_INPUT, .RAPID_OVERRIDE_CODE_A,
		.RAPID_OVERRIDE_CODE_B, .FEED_OVERRIDE_CODE, .OVERRIDE_CANCEL_INPUT,
		.COMMON_FINISH_INPUT, .M_FINISH_INPUT, .M_RESPONSE_INPUT,
		.CYCLE_START_INDICATOR, .FEED_HOLD_INDICATOR, .OPTIONAL_SKIP_ECHO,
		.RESTART_IN_PROGRESS, .RESTART_SCREEN, .DRY_RUN_MOVE, .RESTART_AXIS,
		.M_STROBE, .M_CODE_BITS, .M_ALARM, .RAPID_SPEED, .FEED_OVERRIDE_PCT);
	cpo_plc_model plc_u (.clk(CORE_CLK), .rst_n(RST_N), .strobe(M_STROBE),
		.dly(dly), .common_finish_input(COMMON_FINISH_INPUT), .m_finish_input(M_FINISH_INPUT),
		.response_input(M_RESPONSE_INPUT));
	function [31:0] lf(input [31:0] s);
		lf = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	task summarize;
		$display("compares %0d bad_count %0d", compares, bad_count);
		if (bad_count == 0 && compares > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask
	task chk(input [63:0] got, input [63:0] exp);
		compares = compares + 1;
		if (got !== exp) begin
			bad_count = bad_count + 1;
			$display("ERROR %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task wt(input integer c);
		repeat (c) @(posedge CORE_CLK);
	endtask
	// one apb transfer, held until pready is sampled high
	task apb(input w, input [5:0] a, input [31:0] d);
		integer n;
		@(posedge CORE_CLK);
		PSEL <= 1'h1;
		PWRITE <= w;
		PADDR <= a;
		PWDATA <= d;
		@(posedge CORE_CLK);
		PENABLE <= 1'h1;
		n = 0;
		do begin
			@(posedge CORE_CLK);
			n = n + 1;
		end while (PREADY !== 1'h1 && n < 20);
		rd = PRDATA;
		er = PSLVERR;
		PSEL <= 1'h0;
		PENABLE <= 1'h0;
		if (PREADY !== 1'h1) begin
			bad_count = bad_count + 1;
			summarize;
		end
	endtask
	task rc(input [5:0] a, input [31:0] e);
		apb(1'h0, a, 32'h0);
		chk(rd, e);
	endtask
	// one m code: strobe with its own bit, then release
	// bounded wait for a strobe level; a lost handshake ends the run
	task ws(input l);
		for (k = 0; k < 60 && M_STROBE !== l; k++) @(posedge CORE_CLK);
		if (M_STROBE !== l) begin
			bad_count = bad_count + 1;
			summarize;
		end
	endtask
	task mwait(input integer m);
		ws(1'h1);
		@(negedge CORE_CLK);
		chk(M_CODE_BITS, 64'h1 << m);
		ws(1'h0);
	endtask
	initial begin
		CORE_CLK = 1'h0;
		forever #20 CORE_CLK = ~CORE_CLK;
	end
	initial begin
		#4000000;
		bad_count = bad_count + 1;
		summarize;
	end
	initial begin
		{RST_N, PSEL, PENABLE, PWRITE, PADDR, PWDATA} = '0;
		{SINGLE_STEP_INPUT, OPTIONAL_SKIP_INPUT, RESTART_SELECT_INPUT} = 3'h0;
		{RAPID_OVERRIDE_CODE_A, RAPID_OVERRIDE_CODE_B} = 2'h0;
		OVERRIDE_CANCEL_INPUT = 1'h0;
		FEED_OVERRIDE_CODE = 5'h0;
		dly = 4'h2;
		bad_count = 0;
		compares = 0;
		v = 32'hD71B;
		wt(6);
		RST_N <= 1'h1;
		wt(3);
		// reset values, then an unmapped slot that must be refused
		rc(`CPO_OFF_RAPID_RATE, 32'h1000);
		rc(`CPO_OFF_RAPID_LOW, 32'h0100);
		rc(`CPO_OFF_AXIS_ORDER, 32'hE4);
		rc(`CPO_OFF_MREG_HI, 32'hFFFFFFFF);
		rc(6'h3C, 32'h0);
		chk(er, 1'h1);
		// random override codes against the decode model
		for (i = 0; i < 40; i++) begin
			v = lf(v);
			@(posedge CORE_CLK);
			FEED_OVERRIDE_CODE <= v[4:0];
			OVERRIDE_CANCEL_INPUT <= v[5];
			{RAPID_OVERRIDE_CODE_A, RAPID_OVERRIDE_CODE_B} <= v[7:6];
			OPTIONAL_SKIP_INPUT <= v[8];
			@(posedge CORE_CLK);
			@(negedge CORE_CLK);
			pct = v[5] ? 100 : (v[4:0] > 20 ? 200 : v[4:0] * 10);
			rs = v[7:6] == 2'h3 ? 16'h1000 : v[7:6] == 2'h1 ? 16'h0800 :
				v[7:6] == 2'h2 ? 16'h0400 : 16'h0100;
			chk(FEED_OVERRIDE_PCT, pct);
			chk(RAPID_SPEED, rs);
			chk(OPTIONAL_SKIP_ECHO, v[8]);
		end
		rc(`CPO_OFF_SPEED, {8'h0, pct[7:0], rs});
		OPTIONAL_SKIP_INPUT <= 1'h0;
		SINGLE_STEP_INPUT <= 1'h1;
		// single step: thread chain keeps running, last thread block stops
		apb(1'h1, `CPO_OFF_CTRL, 32'h3);
		for (i = 0; i < 2; i++) begin
			apb(1'h1, `CPO_OFF_BLOCK, 32'h3 - 2 * i);
			wt(3);
			apb(1'h1, `CPO_OFF_CTRL, 32'h5);
			wt(3);
			apb(1'h0, `CPO_OFF_STATUS, 32'h0);
			chk(rd[7], i == 0);
		end
		// canned cycle stop, resume, then block end
		apb(1'h1, `CPO_OFF_BLOCK, 32'h10);
		apb(1'h1, `CPO_OFF_CTRL, 32'h3);
		wt(3);
		apb(1'h1, `CPO_OFF_CTRL, 32'h5);
		wt(3);
		chk({CYCLE_START_INDICATOR, FEED_HOLD_INDICATOR}, 2'h1);
		apb(1'h1, `CPO_OFF_CTRL, 32'h3);
		wt(3);
		chk({CYCLE_START_INDICATOR, FEED_HOLD_INDICATOR}, 2'h2);
		apb(1'h1, `CPO_OFF_CTRL, 32'h5);
		wt(3);
		chk({CYCLE_START_INDICATOR, FEED_HOLD_INDICATOR}, 2'h0);
		SINGLE_STEP_INPUT <= 1'h0;
		// restart with a reversed axis order
		apb(1'h1, `CPO_OFF_AXIS_ORDER, 32'h1B);
		RESTART_SELECT_INPUT <= 1'h1;
		wt(3);
		chk({RESTART_IN_PROGRESS, RESTART_SCREEN}, 2'h3);
		RESTART_SELECT_INPUT <= 1'h0;
		for (i = 0; i < 4; i++) begin
			wt(3);
			chk({DRY_RUN_MOVE, RESTART_AXIS}, {1'h1, 2'h3 - i[1:0]});
			apb(1'h1, `CPO_OFF_CTRL, 32'h5);
		end
		wt(3);
		chk(RESTART_IN_PROGRESS, 1'h0);
		// two m codes in one block, plc delay taken from the random stream
		dly <= v[3:0];
		apb(1'h1, `CPO_OFF_BLOCK, 32'h00280580);
		mwait(5);
		mwait(40);
		apb(1'h1, `CPO_OFF_CTRL, 32'h5);
		wt(3);
		// unregistered code raises the alarm and never strobes
		apb(1'h1, `CPO_OFF_MREG_LO, 32'hFFFFFF7F);
		apb(1'h1, `CPO_OFF_BLOCK, 32'h0740);
		wt(4);
		chk({M_ALARM, M_STROBE}, 2'h2);
		apb(1'h1, `CPO_OFF_STATUS, 32'h100);
		wt(1);
		chk(M_ALARM, 1'h0);
		apb(1'h1, `CPO_OFF_CTRL, 32'h5);
		wt(3);
		// slash block dropped while skip is high, run when low
		OPTIONAL_SKIP_INPUT <= 1'h1;
		apb(1'h1, `CPO_OFF_BLOCK, 32'h0544);
		wt(4);
		apb(1'h0, `CPO_OFF_STATUS, 32'h0);
		chk({rd[6], M_STROBE}, 2'h0);
		OPTIONAL_SKIP_INPUT <= 1'h0;
		apb(1'h1, `CPO_OFF_BLOCK, 32'h0544);
		mwait(5);
		apb(1'h1, `CPO_OFF_CTRL, 32'h5);
		wt(3);
		// cnc reset while the plc is still busy with a code
		dly <= 4'hF;
		apb(1'h1, `CPO_OFF_BLOCK, 32'h0340);
		ws(1'h1);
		apb(1'h1, `CPO_OFF_CTRL, 32'h9);
		wt(2);
		chk(M_STROBE, 1'h0);
		summarize;
	end
endmodule // test_cpo_operation_signals
`default_nettype wire
